// ==== logic/eps_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "eps_defines.vh"
// =====================================================================
// Operation
// - positioning accel between divisor-derived bounds, cap 2047
// - velocity-mode moves skip acceleration bounds
// - source 0 built-in, 1 external, one only
// - built-in encoder gives 256 counts per turn
// - counter readable, writable full signed range
// - absolute single-turn 0..255, prescaler free
// - nonzero max deviation stops motor on excess
// - scale counts by config, low nibble masked, divided by 512
// - built-in: 4 clears at zero, 1 reverses
// - external: bits 0,1 give A/B null levels
// - external: 8 clears at null, 16 polarity
// - scaled counts align with microstep counter
// - quadrature gives four counts per line
module eps_top
(
   // clock and reset
   input  wire        CLK_SYS,
   input  wire        RESET_N,
   // ahb-lite slave
   input  wire        HSEL,
   input  wire [11:0] HADDR,
   input  wire [1:0]  HTRANS,
   input  wire        HWRITE,
   input  wire [2:0]  HSIZE,
   input  wire [31:0] HWDATA,
   input  wire        HREADY,
   output reg  [31:0] HRDATA,
   output reg         HREADYOUT,
   output reg         HRESP,
   // built-in magnetic sensor angle, 0..255
   input  wire [7:0]  INT_ANGLE,
   // external quadrature_with_index pins
   input  wire        EXT_A,
   input  wire        EXT_B,
   input  wire        EXT_N,
   // motion side
   output reg         MOTOR_STOP,
   output reg         IRQ
);
   // =================================================================
   // synchronisers for pins
   reg  [7:0] ang_s1_ff, ang_s2_ff, ang_last_ff;
   reg  [2:0] ext_s1_ff, ext_s2_ff;
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ang_s1_ff <= 8'h0;
         ang_s2_ff <= 8'h0;
         ext_s1_ff <= 3'h0;
         ext_s2_ff <= 3'h0;
      end
      else
      begin
         ang_s1_ff <= INT_ANGLE;
         ang_s2_ff <= ang_s1_ff;
         ext_s1_ff <= {EXT_N, EXT_B, EXT_A};
         ext_s2_ff <= ext_s1_ff;
      end
   end

   // =================================================================
   // software registers
   reg [31:0] count_ff, cfg_ff, maxdev_ff, motpos_ff, move_ff;
   reg [3:0]  rdiv_ff, pdiv_ff;
   reg [10:0] accel_ff;
   reg        src_ff;
   reg [2:0]  status_ff, mask_ff;
   reg        wr_ff;
   reg [11:0] wa_ff;
   reg        null_arm_ff;

   // =================================================================
   // built-in encoder: one count per angle step, 256 per turn
   wire [7:0] ang_d    = ang_s2_ff - ang_last_ff;
   wire       int_step = (ang_d == 8'h01) || (ang_d == 8'hff);
   wire       int_up   = (ang_d == 8'h01) ^ cfg_ff[`EPS_CFG_INT_REV];
   // zero crossing in either direction
   wire       int_zero = int_step &&
                         ((ang_s2_ff == 8'h00) || (ang_last_ff == 8'h00));
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         ang_last_ff <= 8'h0;
      else
         ang_last_ff <= ang_s2_ff;
   end

   // =================================================================
   // external decoder
   wire q_step, q_up;
   eps_quad u_quad
   (
      .clk       (CLK_SYS),
      .reset_n   (RESET_N),
      .ch_a      (ext_s2_ff[0]),
      .ch_b      (ext_s2_ff[1]),
      .step_ff   (q_step),
      .dir_up_ff (q_up)
   );
   // null event: index at set level with A/B at configured levels
   wire ext_null = (ext_s2_ff[2] == cfg_ff[`EPS_CFG_EXT_NPOL]) &&
                   (ext_s2_ff[0] == cfg_ff[`EPS_CFG_EXT_APOL]) &&
                   (ext_s2_ff[1] == cfg_ff[`EPS_CFG_EXT_BPOL]);

   // =================================================================
   // source selection: one encoder feeds the counter
   wire enc_step = src_ff ? q_step : int_step;
   wire enc_up   = src_ff ? q_up   : int_up;
   wire clr_evt  = src_ff ? (ext_null && null_arm_ff)
                          : (int_zero && cfg_ff[`EPS_CFG_INT_CLR]);
   wire        sc_move;
   wire [31:0] sc_delta;
   eps_scale u_scale
   (
      .clk      (CLK_SYS),
      .reset_n  (RESET_N),
      .scale    (cfg_ff[31:`EPS_CFG_SCALE_LSB]),
      .clear    (clr_evt),
      .step     (enc_step),
      .up       (enc_up),
      .move_ff  (sc_move),
      .delta_ff (sc_delta)
   );

   // =================================================================
   // acceleration bounds from divisor difference
   wire signed [5:0] ddif = $signed({2'h0, rdiv_ff}) - $signed({2'h0, pdiv_ff});
   function [11:0] eps_pow2;
      input signed [5:0] e;
      begin
         if (e < 0)
            eps_pow2 = 12'h0;
         else if (e > 6'sd11)
            eps_pow2 = 12'h800;
         else
            eps_pow2 = 12'h1 << e[3:0];
      end
   endfunction
   wire [11:0] acc_lo   = (ddif < 1) ? 12'h0 : eps_pow2(ddif - 6'sd1);
   wire signed [31:0] dup_w = ddif + `EPS_ACC_UP_OFS;
   wire signed [5:0]  dup   = dup_w[5:0]; // sum fits six signed bits
   wire        up_sat   = dup > 6'sd10;
   wire [11:0] acc_hi_r = eps_pow2(dup) - 12'h1;
   wire [10:0] acc_hi   = up_sat ? `EPS_ACC_MAX : acc_hi_r[10:0];
   wire        acc_bad  = ({1'b0, accel_ff} < acc_lo) || (accel_ff > acc_hi);

   // =================================================================
   // deviation check; zero limit disables
   wire [31:0] diff    = motpos_ff - count_ff;
   wire [31:0] absdiff = diff[31] ? (32'h0 - diff) : diff;
   wire        dev_err = (maxdev_ff != 32'h0) && (absdiff > maxdev_ff);

   // =================================================================
   // bus address phase capture; zero wait states
   wire ap = HSEL && HREADY && HTRANS[1];
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         wr_ff     <= 1'b0;
         wa_ff     <= 12'h0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         HRDATA    <= 32'h0;
      end
      else
      begin
         wr_ff <= ap && HWRITE;
         wa_ff <= HADDR;
         if (ap && !HWRITE)
            case (HADDR)
               `EPS_OFF_COUNT:  HRDATA <= count_ff;
               `EPS_OFF_CONFIG: HRDATA <= cfg_ff;
               `EPS_OFF_MAXDEV: HRDATA <= maxdev_ff;
               `EPS_OFF_SOURCE: HRDATA <= {31'h0, src_ff};
               `EPS_OFF_ABSPOS: HRDATA <= {24'h0, ang_s2_ff};
               `EPS_OFF_MOTPOS: HRDATA <= motpos_ff;
               `EPS_OFF_DIVS:   HRDATA <= {24'h0, pdiv_ff, rdiv_ff};
               `EPS_OFF_ACCEL:  HRDATA <= {21'h0, accel_ff};
               `EPS_OFF_MOVE:   HRDATA <= move_ff;
               `EPS_OFF_STATUS: HRDATA <= {29'h0, status_ff};
               `EPS_OFF_MASK:   HRDATA <= {29'h0, mask_ff};
               `EPS_OFF_LIMITS: HRDATA <= {4'h0, acc_hi_r, 4'h0, acc_lo};
               default:         HRDATA <= 32'h0;
            endcase
      end
   end

   // =================================================================
   // register writes, counter, motion and interrupts
   wire wsel_cnt = wr_ff && (wa_ff == `EPS_OFF_COUNT);
   wire wsel_mov = wr_ff && (wa_ff == `EPS_OFF_MOVE);
   // positioning mode needs legal accel; velocity mode never checked
   wire pos_ok   = !(HWDATA[1:0] == 2'h0 && acc_bad);
   wire acc_evt  = wsel_mov && !pos_ok;
   wire [2:0] ev = {acc_evt, clr_evt, dev_err};
   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         count_ff    <= 32'h0;
         cfg_ff      <= `EPS_RST_CONFIG;
         maxdev_ff   <= 32'h0;
         src_ff      <= 1'b0;
         motpos_ff   <= 32'h0;
         rdiv_ff     <= 4'h0;
         pdiv_ff     <= 4'h0;
         accel_ff    <= 11'h0;
         move_ff     <= 32'h0;
         status_ff   <= 3'h0;
         mask_ff     <= 3'h0;
         null_arm_ff <= 1'b0;
         MOTOR_STOP  <= 1'b0;
         IRQ         <= 1'b0;
      end
      else
      begin
         // software write wins over a coincident count
         if (wsel_cnt)
            count_ff <= HWDATA;
         else if (clr_evt)
            count_ff <= 32'h0;
         else if (sc_move)
            count_ff <= count_ff + sc_delta;
         if (wr_ff)
            case (wa_ff)
               `EPS_OFF_CONFIG: cfg_ff    <= HWDATA;
               `EPS_OFF_MAXDEV: maxdev_ff <= HWDATA;
               `EPS_OFF_SOURCE: src_ff    <= HWDATA[0];
               `EPS_OFF_MOTPOS: motpos_ff <= HWDATA;
               `EPS_OFF_DIVS:
               begin
                  rdiv_ff <= HWDATA[3:0];
                  pdiv_ff <= HWDATA[7:4];
               end
               `EPS_OFF_ACCEL:  accel_ff  <= HWDATA[10:0];
               `EPS_OFF_MASK:   mask_ff   <= HWDATA[2:0];
               default:         ;
            endcase
         // clear-at-next-null arms on config write, one shot
         if (wr_ff && wa_ff == `EPS_OFF_CONFIG)
            null_arm_ff <= HWDATA[`EPS_CFG_EXT_CLR];
         else if (src_ff && clr_evt)
            null_arm_ff <= 1'b0;
         // move: accepted only if legal, else flagged
         if (wsel_mov && pos_ok)
            move_ff <= HWDATA;
         // sticky status, set beats write-one-clear
         if (wr_ff && wa_ff == `EPS_OFF_STATUS)
            status_ff <= (status_ff & ~HWDATA[2:0]) | ev;
         else
            status_ff <= status_ff | ev;
         // stop latches until a new move is accepted
         if (dev_err)
            MOTOR_STOP <= 1'b1;
         else if (wsel_mov && pos_ok)
            MOTOR_STOP <= 1'b0;
         IRQ <= |((status_ff | ev) & mask_ff);
      end
   end
endmodule // eps_top
`default_nettype wire

// ==== logic/eps_defines.vh ====
`ifndef EPS_DEFINES_VH
`define EPS_DEFINES_VH
// =====================================================================
// register byte offsets (word aligned)
`define EPS_OFF_COUNT     12'h000
`define EPS_OFF_CONFIG    12'h004
`define EPS_OFF_MAXDEV    12'h008
`define EPS_OFF_SOURCE    12'h00c
`define EPS_OFF_ABSPOS    12'h010
`define EPS_OFF_MOTPOS    12'h014
`define EPS_OFF_DIVS      12'h018
`define EPS_OFF_ACCEL     12'h01c
`define EPS_OFF_MOVE      12'h020
`define EPS_OFF_STATUS    12'h024
`define EPS_OFF_MASK      12'h028
`define EPS_OFF_LIMITS    12'h02c
// =====================================================================
// configuration word fields
`define EPS_CFG_INT_REV   0
`define EPS_CFG_INT_CLR   2
`define EPS_CFG_EXT_APOL  0
`define EPS_CFG_EXT_BPOL  1
`define EPS_CFG_EXT_CLR   3
`define EPS_CFG_EXT_NPOL  4
`define EPS_CFG_SCALE_LSB 4
// =====================================================================
// reset values and figures
`define EPS_RST_CONFIG    32'h0001_9000
`define EPS_UNITY_SHIFT   9
`define EPS_ACC_MAX       11'h7ff
`define EPS_ACC_UP_OFS    12
// =====================================================================
// status bits
`define EPS_ST_DEV        0
`define EPS_ST_NULL       1
`define EPS_ST_ACC        2
`endif

// ==== logic/eps_quad.v ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// quadrature decoder: four counts per line
module eps_quad
(
   // clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // synchronised channels
   input  wire       ch_a,
   input  wire       ch_b,
   // count pulses
   output reg        step_ff,
   output reg        dir_up_ff
);
   reg [1:0] last_ff;
   wire [1:0] cur = {ch_a, ch_b};
   // gray sequence 00-01-11-10 counts up; double change is dropped
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         last_ff   <= 2'h0;
         step_ff   <= 1'b0;
         dir_up_ff <= 1'b0;
      end
      else
      begin
         last_ff   <= cur;
         step_ff   <= ^(cur ^ last_ff) ;
         dir_up_ff <= (last_ff[1] ^ cur[0]);
      end
   end
endmodule // eps_quad
`default_nettype wire

// ==== logic/eps_scale.v ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// prescaler: each count adds scale/32 (config/512) microsteps, fraction kept
module eps_scale
(
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // control
   input  wire [27:0] scale,
   input  wire        clear,
   input  wire        step,
   input  wire        up,
   // result
   output reg         move_ff,
   output reg  [31:0] delta_ff
);
   reg  [8:0]  frac_ff;
   // whole config word with its low nibble masked, so 512 adds one step
   wire [32:0] sum = {24'h0, frac_ff} + {1'b0, scale, 4'h0};
   // scale word holds bits 31..4 of the config; low nibble never adds
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frac_ff  <= 9'h0;
         move_ff  <= 1'b0;
         delta_ff <= 32'h0;
      end
      else if (clear)
      begin
         frac_ff <= 9'h0;
         move_ff <= 1'b0;
      end
      else
      begin
         move_ff <= step;
         if (step)
         begin
            frac_ff  <= sum[8:0];
            delta_ff <= up ? {8'h0, sum[32:9]}
                           : (32'h0 - {8'h0, sum[32:9]});
         end
      end
   end
endmodule // eps_scale
`default_nettype wire

// ==== bench/eps_enc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// encoder model: magnetic angle plus quadrature pins
module eps_enc_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // command: 1 angle up, 2 step up, 3 step down, 4 double jump
   input  wire logic [2:0] cmd,
   input  wire logic       null_in,
   // sensor side
   output logic      [7:0] angle,
   output logic            ch_a,
   output logic            ch_b,
   output logic            ch_n
);
   logic [7:0] ang_ff;
   logic [1:0] ph_ff;
   // one move per command; jump breaks gray order only when asked
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ang_ff <= 8'h00;
         ph_ff  <= 2'h0;
      end
      else
         case (cmd)
            3'h1: ang_ff <= ang_ff + 8'h01;
            3'h2: ph_ff <= ph_ff + 2'h1;
            3'h3: ph_ff <= ph_ff - 2'h1;
            3'h4: ph_ff <= ph_ff + 2'h2;
            default: ;
         endcase
   end
   // gray code: a single channel toggles per valid step
   assign angle = ang_ff;
   assign ch_a  = ph_ff[1];
   assign ch_b  = ph_ff[1] ^ ph_ff[0];
   assign ch_n  = null_in & (ph_ff == 2'h0);
endmodule // eps_enc_model
`default_nettype wire

// ==== bench/eps_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// port checker
module eps_checker
(
   // clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RESET_N,
   // bus
   input wire logic        HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   // motion
   input wire logic        MOTOR_STOP,
   input wire logic        IRQ
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   logic        rd_ff;
   logic        wr_ff;
   logic [11:0] adr_ff;
   logic [31:0] dev_ff;
   logic [31:0] msk_ff;
   // data phase tracking; shadows mirror limit and mask writes
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         adr_ff <= 12'h000;
         dev_ff <= 32'h0;
         msk_ff <= 32'h0;
      end
      else
      begin
         rd_ff <= HSEL & HREADY & HTRANS[1] & ~HWRITE;
         wr_ff <= HSEL & HREADY & HTRANS[1] & HWRITE;
         adr_ff <= HADDR;
         if (wr_ff && adr_ff == 12'h008)
            dev_ff <= HWDATA;
         if (wr_ff && adr_ff == 12'h028)
            msk_ff <= HWDATA;
      end
   end
   a_ready_high: assert property (HREADYOUT)
      else $error("wait state inserted");
   a_resp_okay: assert property (!HRESP)
      else $error("error response");
   a_unmapped_zero: assert property (rd_ff && adr_ff >= 12'h030 |-> HRDATA == 0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!rd_ff |-> $stable(HRDATA))
      else $error("read data moved without read");
   a_abs_range: assert property (rd_ff && adr_ff == 12'h010 |-> HRDATA[31:8] == 0)
      else $error("angle out of range");
   a_status_bits: assert property (rd_ff && adr_ff == 12'h024 |-> HRDATA[31:3] == 0)
      else $error("status spare bits set");
   a_stop_sticky: assert property (MOTOR_STOP && !(wr_ff && adr_ff == 12'h020) |=> MOTOR_STOP)
      else $error("stop dropped without move");
   a_stop_off: assert property (dev_ff == 0 && $past(dev_ff, 2) == 0 && !MOTOR_STOP |=> !MOTOR_STOP)
      else $error("stop with check disabled");
   a_irq_masked: assert property (msk_ff == 0 && $past(msk_ff) == 0 |-> !IRQ)
      else $error("irq with all masked");
endmodule // eps_checker
bind eps_top eps_checker u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MOTOR_STOP(MOTOR_STOP), .IRQ(IRQ));
`default_nettype wire

// ==== bench/encoder_position_supervisor_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "eps_defines.vh"
// =====================================================================
// bench
module encoder_position_supervisor_test;
   logic CLK_SYS = 0, RESET_N = 0, HWRITE = 0, null_in = 0;
   logic [1:0] HTRANS = 0;
   logic [11:0] HADDR = 0;
   logic [31:0] HWDATA = 0, r, c;
   logic [2:0] cmd = 0;
   wire [31:0] HRDATA;
   wire HREADYOUT, HRESP, EXT_A, EXT_B, EXT_N, MOTOR_STOP, IRQ;
   wire [7:0] INT_ANGLE;
   integer errors = 0, checks_done = 0, i;
   // divs, accel, move kind, expected refusal
   logic [31:0] rows [0:7] = '{32'h3400_0001, 32'h3400_1000, 32'h347f_f000,
      32'h313f_f000, 32'h3140_0001, 32'h2700_f001, 32'h2701_0000, 32'h2700_0100};
   always #50 CLK_SYS = ~CLK_SYS;
   eps_top dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .HSEL(1'b1),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .INT_ANGLE(INT_ANGLE),
      .EXT_A(EXT_A), .EXT_B(EXT_B), .EXT_N(EXT_N),
      .MOTOR_STOP(MOTOR_STOP), .IRQ(IRQ));
   eps_enc_model u_enc (.clk(CLK_SYS), .reset_n(RESET_N), .cmd(cmd),
      .null_in(null_in), .angle(INT_ANGLE), .ch_a(EXT_A), .ch_b(EXT_B),
      .ch_n(EXT_N));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp)
         begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // single transfer; waits on ready in both phases, data taken at end
   task bus(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge CLK_SYS);
         HTRANS <= 2'h2;
         HADDR <= a;
         HWRITE <= w;
         do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
         HTRANS <= 2'h0;
         HWDATA <= d;
         do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
         r = HRDATA;
      end
   endtask
   // settle time covers the pin synchronisers and the count pipeline
   task step(input [2:0] k, input integer n);
      repeat (n)
      begin
         @(posedge CLK_SYS) cmd <= k;
         @(posedge CLK_SYS) cmd <= 3'h0;
         repeat (8) @(posedge CLK_SYS);
      end
   endtask
   task pulse_null;
      begin
         @(posedge CLK_SYS) null_in <= 1'b1;
         repeat (8) @(posedge CLK_SYS);
         null_in <= 1'b0;
         repeat (8) @(posedge CLK_SYS);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial
   begin
      repeat (20) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      @(posedge CLK_SYS);
      check(MOTOR_STOP, 0);
      check(IRQ, 0);
      // acceleration window table, velocity moves exempt
      for (i = 0; i < 8; i = i + 1)
      begin
         bus(1, `EPS_OFF_DIVS, rows[i][31:24]);
         bus(1, `EPS_OFF_ACCEL, rows[i][23:12]);
         bus(1, `EPS_OFF_MOVE, rows[i][11:8]);
         bus(0, `EPS_OFF_STATUS, 0);
         check(r[2], rows[i][0]);
         bus(1, `EPS_OFF_STATUS, 32'h4);
      end
      bus(0, `EPS_OFF_LIMITS, 0);
      check(r, 32'h07ff_0010);
      // interrupt raised, cleared, then masked
      bus(1, `EPS_OFF_MASK, 32'h4);
      bus(1, `EPS_OFF_MOVE, 0);
      repeat (3) @(posedge CLK_SYS);
      check(IRQ, 1);
      bus(1, `EPS_OFF_STATUS, 32'h4);
      repeat (3) @(posedge CLK_SYS);
      check(IRQ, 0);
      bus(1, `EPS_OFF_MASK, 0);
      bus(1, `EPS_OFF_MOVE, 0);
      repeat (3) @(posedge CLK_SYS);
      check(IRQ, 0);
      bus(1, `EPS_OFF_STATUS, 32'h7);
      bus(0, 12'h040, 0);
      check(r, 0);
      // counter range extremes
      bus(1, `EPS_OFF_COUNT, 32'h8000_0000);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 32'h8000_0000);
      bus(1, `EPS_OFF_COUNT, 32'h7fff_ffff);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 32'h7fff_ffff);
      // built-in sensor, unity then double scale reversed
      bus(1, `EPS_OFF_CONFIG, 32'h200);
      bus(1, `EPS_OFF_COUNT, 0);
      step(1, 10);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 10);
      bus(1, `EPS_OFF_CONFIG, 32'h401);
      step(1, 3);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 4);
      bus(0, `EPS_OFF_ABSPOS, 0);
      check(r, 13);
      // external selected: angle motion ignored
      bus(1, `EPS_OFF_SOURCE, 1);
      step(1, 2);
      bus(1, `EPS_OFF_CONFIG, 32'h200);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 4);
      bus(1, `EPS_OFF_COUNT, 0);
      step(2, 8);
      bus(0, `EPS_OFF_COUNT, 0);
      c = r;
      check(c === 32'h8 || c === 32'hffff_fff8, 1);
      step(3, 3);
      step(4, 2);
      step(3, 1);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, c === 32'h8 ? 32'h4 : 32'hffff_fffc);
      // armed clear at null with both channels low, then disarmed
      bus(1, `EPS_OFF_COUNT, 32'h77);
      bus(1, `EPS_OFF_CONFIG, 32'h218);
      pulse_null;
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 0);
      bus(1, `EPS_OFF_COUNT, 7);
      pulse_null;
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 7);
      // built-in clear at zero crossing, combined with reverse
      bus(1, `EPS_OFF_SOURCE, 0);
      step(1, 240);
      bus(1, `EPS_OFF_COUNT, 100);
      bus(1, `EPS_OFF_CONFIG, 32'h205);
      step(1, 1);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 0);
      // deviation stop: off at zero limit, on above limit
      bus(1, `EPS_OFF_MOTPOS, 1000);
      bus(1, `EPS_OFF_MAXDEV, 0);
      repeat (10) @(posedge CLK_SYS);
      check(MOTOR_STOP, 0);
      bus(1, `EPS_OFF_MAXDEV, 10);
      repeat (10) @(posedge CLK_SYS);
      check(MOTOR_STOP, 1);
      bus(1, `EPS_OFF_MOTPOS, 10);
      bus(1, `EPS_OFF_MOVE, 1);
      repeat (10) @(posedge CLK_SYS);
      check(MOTOR_STOP, 0);
      // mid-run reset brings back the defaults
      RESET_N <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      check(MOTOR_STOP, 0);
      bus(0, `EPS_OFF_CONFIG, 0);
      check(r, 32'h0001_9000);
      bus(0, `EPS_OFF_COUNT, 0);
      check(r, 0);
      finish_test;
   end
   // watchdog well past the expected run
   initial
   begin
      repeat (60000) @(posedge CLK_SYS);
      errors = errors + 1;
      finish_test;
   end
endmodule // encoder_position_supervisor_test
`default_nettype wire
